// *** modem_host_pin_interface.sv ***
// host-facing pins of the modem: serial data, handshakes, escape, ring and hook
// Function
// - escape in data mode enters command mode and stays off-hook.
// - go-online command received in command mode returns to data mode.
// - ring indicate is open drain: low when active, released otherwise.
// - hook relay drive pulls low when active, pulls high when inactive.
// - reset is active low; low holds device in reset.
// - carrier detect output is active low.
// - set ready and clear to send outputs are active low.
// - transmit data accepted on non-inverted input.
// - received line data delivered on non-inverted output.
// - ring detect report drives ring indicate low.
// - hook relay high means on-hook, low means off-hook.
`timescale 1ns/1ns
module modem_host_pin_interface
  import pin_if_pkg::*;
#(
  parameter int unsigned BIT_CNT = BIT_CYCLES
)(
  input  wire logic       core_clk_i,
  input  wire logic       rst_b_i,
  input  wire logic       host_txd_i,
  output logic            host_rxd_o,
  input  wire logic       terminal_ready_n_i,
  input  wire logic       request_to_send_n_i,
  input  wire logic       escape_to_command_i,
  output logic            carrier_detect_n_o,
  output logic            set_ready_n_o,
  output logic            clear_to_send_n_o,
  output logic            ring_indicate_n_o,
  output logic            ring_indicate_n_oe_o,
  output logic            hook_relay_drive_n_o,
  input  wire logic       ring_detect_i,
  input  wire logic       dial_request_i,
  input  wire logic       carrier_i,
  input  wire logic       line_byte_valid_i,
  input  wire logic [7:0] line_byte_i,
  output logic            line_byte_valid_o,
  input  wire logic       line_byte_ready_i,
  output logic      [7:0] line_byte_o
);
  typedef struct packed
  {
    mode_type         mode;
    logic [CNT_W-1:0] rx_cnt;
    logic [3:0]       rx_bit;
    logic             rx_busy;
    logic [7:0]       rx_sh;
    logic             rx_done;
    logic [7:0]       rx_byte;
    logic [CNT_W-1:0] tx_cnt;
    logic [3:0]       tx_bit;
    logic             tx_busy;
    logic [8:0]       tx_sh;
    logic             txd;
    logic             ring;
    status_type       status;
  } state_type;

  state_type  st_r;
  state_type  st_nxt;
  logic       fifo_valid;
  logic       fifo_pop;
  logic [7:0] fifo_data;
  logic       fifo_ready;
  logic       host_byte_valid;

  // received host bytes go to the line in data mode only
  assign host_byte_valid = st_r.rx_done && (st_r.mode == MODE_DATA);

  // the fifo absorbs line bytes while the host serialiser is busy
  byte_fifo #(
    .WIDTH (DATA_BITS),
    .DEPTH (FIFO_DEPTH)
  ) u_line_fifo (
    .core_clk_i  (core_clk_i),
    .rst_b_i     (rst_b_i),
    .in_valid_i  (line_byte_valid_i && st_r.mode == MODE_DATA),
    .in_ready_o  (fifo_ready),
    .in_data_i   (line_byte_i),
    .out_valid_o (fifo_valid),
    .out_ready_i (fifo_pop),
    .out_data_o  (fifo_data)
  );

  // terminal ready low lets the modem hand bytes to the host
  assign fifo_pop = fifo_valid && !st_r.tx_busy && !terminal_ready_n_i;

  function automatic logic [CNT_W-1:0] bit_len(input logic half);
    bit_len = half ? CNT_W'(BIT_CNT / 2) : CNT_W'(BIT_CNT - 1);
  endfunction

  always_comb
  begin
    st_nxt         = st_r;
    st_nxt.rx_done = 1'b0;
    // receiver: sample host_txd_i mid-bit
    if (!st_r.rx_busy)
    begin
      if (host_txd_i != LINE_IDLE)
      begin
        st_nxt.rx_busy = 1'b1;
        st_nxt.rx_bit  = 4'h0;
        st_nxt.rx_cnt  = bit_len(1'b1);
      end
    end
    else if (st_r.rx_cnt != '0)
      st_nxt.rx_cnt = st_r.rx_cnt - 1'b1;
    else
    begin
      st_nxt.rx_cnt = bit_len(1'b0);
      st_nxt.rx_bit = st_r.rx_bit + 4'h1;
      if (st_r.rx_bit == 4'h0 && host_txd_i)
        st_nxt.rx_busy = 1'b0;
      else if (st_r.rx_bit == 4'h9)
      begin
        st_nxt.rx_busy = 1'b0;
        st_nxt.rx_done = host_txd_i;
        st_nxt.rx_byte = st_r.rx_sh;
      end
      else if (st_r.rx_bit != 4'h0)
        st_nxt.rx_sh = {host_txd_i, st_r.rx_sh[7:1]};
    end
    // transmitter toward host_rxd_o
    if (!st_r.tx_busy)
    begin
      st_nxt.txd = LINE_IDLE;
      if (fifo_pop)
      begin
        st_nxt.tx_busy = 1'b1;
        st_nxt.tx_sh   = {1'b1, fifo_data};
        st_nxt.tx_bit  = 4'h0;
        st_nxt.tx_cnt  = bit_len(1'b0);
        st_nxt.txd     = 1'b0;
      end
    end
    else if (st_r.tx_cnt != '0)
      st_nxt.tx_cnt = st_r.tx_cnt - 1'b1;
    else if (st_r.tx_bit == 4'h9)
    begin
      st_nxt.tx_busy = 1'b0;
      st_nxt.txd     = LINE_IDLE;
    end
    else
    begin
      st_nxt.tx_cnt = bit_len(1'b0);
      st_nxt.tx_bit = st_r.tx_bit + 4'h1;
      st_nxt.txd    = st_r.tx_sh[0];
      st_nxt.tx_sh  = {1'b1, st_r.tx_sh[8:1]};
    end
    // mode control
    case (st_r.mode)
      MODE_ON_HOOK:
        if (dial_request_i && !terminal_ready_n_i)
          st_nxt.mode = MODE_COMMAND;
      MODE_DATA:
        if (escape_to_command_i)
          st_nxt.mode = MODE_COMMAND;
      MODE_COMMAND:
        if (terminal_ready_n_i)
          st_nxt.mode = MODE_ON_HOOK;
        else if (st_r.rx_done && st_r.rx_byte == ONLINE_CMD && !escape_to_command_i)
          st_nxt.mode = MODE_DATA;
      default:
        st_nxt.mode = MODE_ON_HOOK;
    endcase
    st_nxt.ring                 = ring_detect_i;
    st_nxt.status.carrier       = carrier_i && (st_r.mode == MODE_DATA);
    st_nxt.status.set_ready     = (st_r.mode != MODE_ON_HOOK);
    st_nxt.status.clear_to_send = (st_r.mode == MODE_DATA) && !request_to_send_n_i && fifo_ready;
  end

  // synchronous active-low reset holds everything idle
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_b_i)
    begin
      st_r      <= '0;
      st_r.mode <= MODE_ON_HOOK;
      st_r.txd  <= LINE_IDLE;
    end
    else
      st_r <= st_nxt;
  end

  assign host_rxd_o           = st_r.txd;
  assign line_byte_valid_o    = host_byte_valid && st_r.status.clear_to_send;
  assign line_byte_o          = st_r.rx_byte;
  assign carrier_detect_n_o   = !st_r.status.carrier;
  assign set_ready_n_o        = !st_r.status.set_ready;
  assign clear_to_send_n_o    = !st_r.status.clear_to_send;
  // open drain: output low, enable low while pulling
  assign ring_indicate_n_o    = 1'b0;
  assign ring_indicate_n_oe_o = !st_r.ring;
  // off-hook in command and data modes
  assign hook_relay_drive_n_o = (st_r.mode == MODE_ON_HOOK);

  sequence escape_in_data;
    st_r.mode == MODE_DATA && escape_to_command_i;
  endsequence

  chk_escape_command : assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    escape_in_data |=> st_r.mode == MODE_COMMAND && !hook_relay_drive_n_o)
    else $error("escape did not enter command mode off-hook");
  chk_online_return : assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (st_r.mode == MODE_COMMAND && st_r.rx_done && st_r.rx_byte == ONLINE_CMD
     && !terminal_ready_n_i && !escape_to_command_i) |=> st_r.mode == MODE_DATA)
    else $error("online command did not return to data mode");
  chk_ring_drive : assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    ring_detect_i |=> !ring_indicate_n_oe_o && !ring_indicate_n_o)
    else $error("ring not indicated");
  chk_ring_release : assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    !ring_detect_i |=> ring_indicate_n_oe_o)
    else $error("ring indicate not released");
  // going on-hook only from command mode once terminal ready is released
  chk_hook_meaning : assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    $rose(hook_relay_drive_n_o) |-> $past(st_r.mode) == MODE_COMMAND && $past(terminal_ready_n_i))
    else $error("hook released outside command mode");
  chk_reset_idle : assert property (@(posedge core_clk_i)
    !rst_b_i |=> hook_relay_drive_n_o && host_rxd_o && ring_indicate_n_oe_o)
    else $error("reset did not idle the pins");
  chk_carrier_low : assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (carrier_i && st_r.mode == MODE_DATA && $stable(st_r.mode)) |=> !carrier_detect_n_o)
    else $error("carrier detect not active low");
  chk_ready_low : assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (st_r.mode == MODE_ON_HOOK) |=> (set_ready_n_o && clear_to_send_n_o))
    else $error("handshakes active while on-hook");
  chk_tx_start_bit : assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    fifo_pop |=> !host_rxd_o [*8])
    else $error("start bit too short");
endmodule

// *** pin_if_pkg.sv ***
// shared constants and carrier types for the modem host pin interface
package pin_if_pkg;
  localparam int unsigned CLK_HZ        = 250000000;
  localparam int unsigned BAUD          = 9600;
  localparam int unsigned BIT_CYCLES    = CLK_HZ / BAUD;
  localparam int unsigned DATA_BITS     = 8;
  localparam int unsigned FIFO_DEPTH    = 8;
  localparam int unsigned CNT_W         = 16;
  localparam logic [7:0]  ONLINE_CMD    = 8'h4F;
  localparam logic        LINE_IDLE     = 1'b1;

  typedef enum logic [2:0]
  {
    MODE_ON_HOOK = 3'b001,
    MODE_COMMAND = 3'b010,
    MODE_DATA    = 3'b100
  } mode_type;

  typedef struct packed
  {
    logic       valid;
    logic [7:0] data;
  } byte_type;

  typedef struct packed
  {
    logic carrier;
    logic set_ready;
    logic clear_to_send;
  } status_type;
endpackage

// *** byte_fifo.sv ***
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ns
module byte_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
)(
  input  wire logic             core_clk_i,
  input  wire logic             rst_b_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int unsigned AW = $clog2(DEPTH);
  typedef struct packed
  {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0]   count;
  } fifo_state_type;

  logic [WIDTH-1:0] mem [DEPTH];
  fifo_state_type   st_r;
  fifo_state_type   st_nxt;
  logic             push;
  logic             pop;

  assign in_ready_o  = (st_r.count != (AW+1)'(DEPTH));
  assign out_valid_o = (st_r.count != '0);
  assign out_data_o  = mem[st_r.rd];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_comb
  begin
    st_nxt = st_r;
    if (push)
      st_nxt.wr = st_r.wr + 1'b1;
    if (pop)
      st_nxt.rd = st_r.rd + 1'b1;
    if (push && !pop)
      st_nxt.count = st_r.count + 1'b1;
    else if (pop && !push)
      st_nxt.count = st_r.count - 1'b1;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_b_i)
      st_r <= '0;
    else
      st_r <= st_nxt;
    if (push)
      mem[st_r.wr] <= in_data_i;
  end

  chk_fifo_no_overflow : assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    st_r.count <= (AW+1)'(DEPTH))
    else $error("fifo count above depth");
endmodule

// *** host_model.sv ***
// behavioural host: serial framer, deframer and ring pull-up
`timescale 1ns/1ns
module host_model #(
  parameter int BIT = 16
)(
  input  wire logic core_clk_i,
  input  wire logic rxd_i,
  input  wire logic ring_n_i,
  input  wire logic ring_oe_i,
  output logic      txd_o,
  output wire logic ring_line_o
);
  // pull-up wins whenever the modem lets go
  assign ring_line_o = ring_oe_i ? 1'b1 : ring_n_i;
  initial txd_o = 1'b1;
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      txd_o <= f[i];
      repeat (BIT) @(posedge core_clk_i);
    end
  endtask
  task automatic recv_byte(output logic [7:0] b, output logic stop);
    wait (rxd_i === 1'b0);
    repeat (BIT / 2) @(posedge core_clk_i);
    for (int i = 0; i < 8; i++)
    begin
      repeat (BIT) @(posedge core_clk_i);
      b[i] = rxd_i;
    end
    repeat (BIT) @(posedge core_clk_i);
    stop = rxd_i;
  endtask
endmodule

// *** tb.sv ***
// self-checking bench for the modem host pin interface
`timescale 1ns/1ns
module tb;
  import pin_if_pkg::*;
  localparam int BIT = 16;
  logic       clk = 1'b0, rst_b = 1'b0, dtr_n = 1'b1, rts_n = 1'b0, escape_req = 1'b0;
  logic       ring = 1'b0, dial = 1'b0, car = 1'b0, lv = 1'b0;
  logic [7:0] lb = 8'h00;
  logic       txd, rxd, dcd_n, dsr_n, cts_n, ri_n, ri_oe, hook_n, ring_line, bv;
  logic [7:0] bo;
  logic [7:0] host_q[$];
  int         n_mismatch = 0, compares = 0, cycles = 0;
  always #2 clk = ~clk;
  modem_host_pin_interface #(.BIT_CNT(BIT)) dut (
    .core_clk_i(clk), .rst_b_i(rst_b), .host_txd_i(txd), .host_rxd_o(rxd),
    .terminal_ready_n_i(dtr_n), .request_to_send_n_i(rts_n), .escape_to_command_i(escape_req),
    .carrier_detect_n_o(dcd_n), .set_ready_n_o(dsr_n), .clear_to_send_n_o(cts_n),
    .ring_indicate_n_o(ri_n), .ring_indicate_n_oe_o(ri_oe), .hook_relay_drive_n_o(hook_n),
    .ring_detect_i(ring), .dial_request_i(dial), .carrier_i(car), .line_byte_valid_i(lv),
    .line_byte_i(lb), .line_byte_valid_o(bv), .line_byte_ready_i(1'b1), .line_byte_o(bo));
  host_model #(.BIT(BIT)) hm (.core_clk_i(clk), .rxd_i(rxd), .ring_n_i(ri_n), .ring_oe_i(ri_oe),
    .txd_o(txd), .ring_line_o(ring_line));
  // valid is a one-cycle pulse, so every edge is watched
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (bv === 1'b1)
      host_q.push_back(bo);
    if (cycles == 20000)
    begin
      n_mismatch++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    if (n_mismatch == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wait_chk(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic t_reset();
    wait_chk(11);
    check({hook_n, rxd, ring_line, dcd_n, dsr_n, cts_n}, 8'h3F);
    @(posedge clk);
    rst_b <= 1'b1;
  endtask
  task automatic t_ring();
    @(posedge clk);
    ring <= 1'b1;
    wait_chk(2);
    check(ring_line, 8'h00);
    @(posedge clk);
    ring <= 1'b0;
    wait_chk(2);
    check(ring_line, 8'h01);
  endtask
  task automatic t_online();
    @(posedge clk);
    dtr_n <= 1'b0;
    dial <= 1'b1;
    @(posedge clk);
    dial <= 1'b0;
    wait_chk(2);
    check({hook_n, dsr_n, cts_n}, 8'h01);
    @(posedge clk);
    hm.send_byte(ONLINE_CMD);
    car <= 1'b1;
    wait_chk(4);
    check({cts_n, dcd_n}, 8'h00);
    check(8'(host_q.size()), 8'h00);
    @(posedge clk);
    rts_n <= 1'b1;
    wait_chk(2);
    check(cts_n, 8'h01);
    @(posedge clk);
    rts_n <= 1'b0;
  endtask
  task automatic t_host_tx();
    hm.send_byte(8'hA5);
    hm.send_byte(8'h3C);
    wait_chk(4);
    check(8'(host_q.size()), 8'h02);
    check(host_q[0], 8'hA5);
    check(host_q[1], 8'h3C);
  endtask
  task automatic t_line_rx();
    logic [7:0] b;
    logic       s;
    @(posedge clk);
    dtr_n <= 1'b1;
    for (int i = 0; i < FIFO_DEPTH; i++)
    begin
      @(posedge clk);
      lv <= 1'b1;
      lb <= 8'(8'h81 + i * 8'h13);
    end
    @(posedge clk);
    lv <= 1'b0;
    wait_chk(2);
    check(cts_n, 8'h01);
    @(posedge clk);
    dtr_n <= 1'b0;
    for (int i = 0; i < FIFO_DEPTH; i++)
    begin
      hm.recv_byte(b, s);
      check(b, 8'(8'h81 + i * 8'h13));
      check(s, 8'h01);
    end
    wait_chk(2);
    check(cts_n, 8'h00);
  endtask
  task automatic t_escape();
    @(posedge clk);
    escape_req <= 1'b1;
    @(posedge clk);
    escape_req <= 1'b0;
    wait_chk(2);
    check({hook_n, dsr_n, cts_n}, 8'h01);
    @(posedge clk);
    hm.send_byte(ONLINE_CMD);
    wait_chk(4);
    check(cts_n, 8'h00);
    @(posedge clk);
    escape_req <= 1'b1;
    @(posedge clk);
    escape_req <= 1'b0;
    dtr_n <= 1'b1;
    wait_chk(3);
    check({hook_n, dsr_n}, 8'h03);
  endtask
  initial
  begin
    t_reset();
    t_ring();
    t_online();
    t_host_tx();
    t_line_rx();
    t_escape();
    end_of_test();
  end
endmodule
